// ---- logic/tmwc_params.svh ----
// constants of the timer mode and waveform core
//==================================================================
//==================================================================
`ifndef TMWC_PARAMS_SVH
`define TMWC_PARAMS_SVH
// register byte offsets
`define TMWC_OFF_CTRL 8'h00
`define TMWC_OFF_ACT 8'h04
`define TMWC_OFF_DIR 8'h08
`define TMWC_OFF_FORCE 8'h0c
`define TMWC_OFF_CNT 8'h10
`define TMWC_OFF_CMPA 8'h14
`define TMWC_OFF_CMPB 8'h18
`define TMWC_OFF_CMPC 8'h1c
`define TMWC_OFF_CAPT 8'h20
`define TMWC_OFF_FLAG 8'h24
`define TMWC_OFF_STAT 8'h28
// control fields
`define TMWC_CTRL_RUN 4
// flag bit positions
`define TMWC_FLG_OVF 0
`define TMWC_FLG_CMPA 1
`define TMWC_FLG_CAPT 4
// mode select codes
`define TMWC_M_NORMAL 4'h0
`define TMWC_M_CTC_A 4'h4
`define TMWC_M_FAST8 4'h5
`define TMWC_M_FAST9 4'h6
`define TMWC_M_FAST10 4'h7
`define TMWC_M_CTC_CAP 4'hc
`define TMWC_M_FAST_CAP 4'he
`define TMWC_M_FAST_A 4'hf
// fixed tops and extremes
`define TMWC_TOP8 16'h00ff
`define TMWC_TOP9 16'h01ff
`define TMWC_TOP10 16'h03ff
`define TMWC_MAX 16'hffff
`define TMWC_BOTTOM 16'h0000
// action codes
`define TMWC_ACT_NONE 2'h0
`define TMWC_ACT_TOGGLE 2'h1
`define TMWC_ACT_CLEAR 2'h2
`define TMWC_ACT_SET 2'h3
`endif

// ---- logic/tmwc_pkg.sv ----
// types of the timer mode and waveform core
`default_nettype none
package tmwc_pkg;
    // counter sequence classes
    typedef enum logic [1:0] {
        TMWC_SEQ_NORMAL,
        TMWC_SEQ_CTC,
        TMWC_SEQ_FAST
    } tmwc_seq_e;
    // per-channel events into the output unit
    typedef struct packed {
        logic [1:0] action;
        logic pwm;
        logic toggle_ok;
        logic match;
        logic top_evt;
        logic force_evt;
    } tmwc_chan_s;
endpackage : tmwc_pkg
`default_nettype wire

// ---- logic/tmwc_sync.sv ----
// three-stage pin synchroniser with agreement filter
`default_nettype none
module tmwc_sync (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // pin side
    input wire logic pin_in,
    // core side
    output logic rise
);
    logic s1_q, s2_q, s3_q, lvl_q; // stages and filtered level
    logic lvl_d;
    // level moves only when stages two and three agree
    assign lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
    assign rise = lvl_d & ~lvl_q;
    //==============================================================
    // stages
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            lvl_q <= 1'b0;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= lvl_d;
        end
    end
endmodule : tmwc_sync
`default_nettype wire

// ---- logic/tmwc_chan.sv ----
// one compare output unit: internal output state
`include "tmwc_params.svh"
`default_nettype none
module tmwc_chan (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // events from the core
    input wire tmwc_pkg::tmwc_chan_s ev,
    // internal output state
    output logic state
);
    logic state_q, state_d;
    logic on_match, at_top, non_pwm_evt;
    // non-pwm: match or force applies the action
    assign non_pwm_evt = ev.match | ev.force_evt;
    assign on_match = ev.pwm ? ev.match : non_pwm_evt;
    assign at_top = ev.pwm & ev.top_evt;
    //==============================================================
    // next output state, top wins over match in fast pwm
    always_comb begin
        state_d = state_q;
        case (ev.action)
            `TMWC_ACT_NONE: state_d = state_q;
            `TMWC_ACT_TOGGLE: begin
                if (on_match && (!ev.pwm || ev.toggle_ok)) begin
                    state_d = ~state_q;
                end
            end
            `TMWC_ACT_CLEAR: begin
                if (at_top) state_d = 1'b0;
                else if (on_match) state_d = ev.pwm;
            end
            `TMWC_ACT_SET: begin
                if (at_top) state_d = 1'b1;
                else if (on_match) state_d = ~ev.pwm;
            end
            default: state_d = state_q;
        endcase
    end
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) state_q <= 1'b0;
        else state_q <= state_d;
    end
    assign state = state_q;
endmodule : tmwc_chan
`default_nettype wire

// ---- logic/tmwc_core.sv ----
// timer mode and waveform core with apb register slave
`include "tmwc_params.svh"
`default_nettype none
module tmwc_core (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // capture pin and interrupt acknowledge
    input wire logic capt_pin,
    input wire logic [4:0] flag_ack,
    // waveform pins
    output logic [2:0] wave_out,
    output logic [2:0] wave_oe,
    // flags seen by the interrupt controller
    output logic [4:0] flags
);
    //==============================================================
    // functions
    //==============================================================
    // modes this core implements
    function automatic logic is_sup(input logic [3:0] m);
        is_sup = (m == `TMWC_M_NORMAL) || (m == `TMWC_M_CTC_A) ||
                 (m == `TMWC_M_CTC_CAP) || (m == `TMWC_M_FAST8) ||
                 (m == `TMWC_M_FAST9) || (m == `TMWC_M_FAST10) ||
                 (m == `TMWC_M_FAST_CAP) || (m == `TMWC_M_FAST_A);
    endfunction : is_sup

    // mask of valid compare bits for the mode
    function automatic logic [15:0] res_mask(input logic [3:0] m);
        case (m)
            `TMWC_M_FAST8: res_mask = `TMWC_TOP8;
            `TMWC_M_FAST9: res_mask = `TMWC_TOP9;
            `TMWC_M_FAST10: res_mask = `TMWC_TOP10;
            default: res_mask = `TMWC_MAX;
        endcase
    endfunction : res_mask

    //==============================================================
    // registers
    //==============================================================
    logic [3:0] mode_q; // mode as written
    logic [3:0] emode_q, emode_d; // mode in effect
    logic run_q; // counter running
    logic [5:0] act_q; // two action bits per channel
    logic [2:0] dir_q; // pin direction bits
    logic [15:0] cnt_q, cnt_d; // count value
    logic [15:0] buf_q [3]; // compare values as written
    logic [15:0] cmp_q [3]; // active compare copies
    logic [15:0] icr_q, icr_d; // capture value register
    logic [4:0] flag_q, flag_d; // sticky flags
    logic blk_q; // match block after count write
    logic pready_q, pslverr_q; // apb answer
    logic [31:0] prdata_q; // apb read data
    logic [2:0] wave_q, oe_q; // pin drivers

    //==============================================================
    // bus decode
    //==============================================================
    logic setup_ph, wr_en;
    logic hit_ctrl, hit_act, hit_dir, hit_force, hit_cnt;
    logic hit_cmpa, hit_cmpb, hit_cmpc, hit_capt;
    logic hit_flag, hit_stat, mapped;
    logic [2:0] hit_cmp;
    // setup phase samples read data and decode
    assign setup_ph = psel & ~penable;
    // write lands on the completing access edge
    assign wr_en = psel & penable & pready_q & pwrite;
    assign hit_ctrl = (paddr == `TMWC_OFF_CTRL);
    assign hit_act = (paddr == `TMWC_OFF_ACT);
    assign hit_dir = (paddr == `TMWC_OFF_DIR);
    assign hit_force = (paddr == `TMWC_OFF_FORCE);
    assign hit_cnt = (paddr == `TMWC_OFF_CNT);
    assign hit_cmpa = (paddr == `TMWC_OFF_CMPA);
    assign hit_cmpb = (paddr == `TMWC_OFF_CMPB);
    assign hit_cmpc = (paddr == `TMWC_OFF_CMPC);
    assign hit_capt = (paddr == `TMWC_OFF_CAPT);
    assign hit_flag = (paddr == `TMWC_OFF_FLAG);
    assign hit_stat = (paddr == `TMWC_OFF_STAT);
    assign hit_cmp = {hit_cmpc, hit_cmpb, hit_cmpa};
    assign mapped = hit_ctrl | hit_act | hit_dir | hit_force |
                    hit_cnt | (|hit_cmp) | hit_capt | hit_flag |
                    hit_stat;

    //==============================================================
    // mode classes and top selection
    //==============================================================
    tmwc_pkg::tmwc_seq_e seq; // sequence from mode select only
    logic is_fast;
    logic top_by_a, top_by_cap;
    logic [15:0] top_val;
    // only the mode select field decides the sequence
    assign seq = (emode_q == `TMWC_M_CTC_A ||
                  emode_q == `TMWC_M_CTC_CAP) ?
                 tmwc_pkg::TMWC_SEQ_CTC :
                 (emode_q == `TMWC_M_NORMAL) ?
                 tmwc_pkg::TMWC_SEQ_NORMAL :
                 tmwc_pkg::TMWC_SEQ_FAST;
    assign is_fast = (seq == tmwc_pkg::TMWC_SEQ_FAST);
    // register that defines top
    assign top_by_a = (emode_q == `TMWC_M_CTC_A) ||
                      (emode_q == `TMWC_M_FAST_A);
    assign top_by_cap = (emode_q == `TMWC_M_CTC_CAP) ||
                        (emode_q == `TMWC_M_FAST_CAP);
    // fixed or register top, capture register unbuffered
    assign top_val = top_by_a ? cmp_q[0] :
                     top_by_cap ? icr_q :
                     res_mask(emode_q);

    //==============================================================
    // counter
    //==============================================================
    logic cnt_wr, tick, at_top, clr_top, wrap;
    logic [15:0] cnt_inc;
    assign cnt_wr = wr_en & hit_cnt;
    // a timer cycle is any running cycle not overwritten
    assign tick = run_q & ~cnt_wr;
    // top reached, normal mode never clears
    assign at_top = (seq != tmwc_pkg::TMWC_SEQ_NORMAL) &&
                    (cnt_q == top_val);
    assign clr_top = tick & at_top;
    // a missed top still wraps through max
    assign wrap = (cnt_q == `TMWC_MAX);
    assign cnt_inc = cnt_q + 16'h0001;
    // clear the cycle after top, else count up
    assign cnt_d = cnt_wr ? pwdata[15:0] :
                   clr_top ? `TMWC_BOTTOM :
                   tick ? cnt_inc : cnt_q;

    //==============================================================
    // compare matches and buffering
    //==============================================================
    logic [2:0] match, force_evt;
    logic [15:0] cmp_wval;
    logic [15:0] cmp_d [3];
    // bits above fixed resolution forced to zero
    assign cmp_wval = pwdata[15:0] & res_mask(emode_q);
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_cmp
            // equality in a timer cycle not blocked
            assign match[gi] = tick & ~blk_q &
                               (cnt_q == cmp_q[gi]);
            // force strobes only outside pwm
            assign force_evt[gi] = wr_en & hit_force &
                                   pwdata[gi] & ~is_fast;
            // direct in non-pwm, reload at top in fast pwm
            assign cmp_d[gi] = ~is_fast ? buf_q[gi] :
                               clr_top ? buf_q[gi] :
                               cmp_q[gi];
        end
    endgenerate

    //==============================================================
    // capture unit
    //==============================================================
    logic capt_rise, capt_evt;
    // filtered capture pin edge
    tmwc_sync u_capt_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(capt_pin),
        .rise(capt_rise)
    );
    // capture idle while its register defines top
    assign capt_evt = capt_rise & ~top_by_cap;
    assign icr_d = (wr_en & hit_capt) ? pwdata[15:0] :
                   capt_evt ? cnt_q : icr_q;

    //==============================================================
    // flags
    //==============================================================
    logic ovf_set, cmpa_top_set, capt_set;
    logic [4:0] flag_set, flag_clr;
    // overflow at top in fast pwm, else at max wrap
    assign ovf_set = tick & (is_fast ? at_top :
                     wrap);
    // top flag of compare A in fast pwm on top
    assign cmpa_top_set = clr_top & is_fast & top_by_a;
    // capture flag on top when it defines top
    assign capt_set = capt_evt |
                      (clr_top & top_by_cap);
    assign flag_set = {capt_set, match[2], match[1],
                       match[0] | cmpa_top_set, ovf_set};
    // software one-to-clear or interrupt acknowledge
    assign flag_clr = flag_ack |
                      ((wr_en & hit_flag) ? pwdata[4:0] : 5'h00);
    // set beats clear in the same cycle
    assign flag_d = (flag_q & ~flag_clr) | flag_set;

    //==============================================================
    // mode register, unsupported codes keep the old sequence
    //==============================================================
    assign emode_d = (wr_en & hit_ctrl & is_sup(pwdata[3:0])) ?
                     pwdata[3:0] : emode_q;

    //==============================================================
    // output units
    //==============================================================
    logic [2:0] state;
    tmwc_pkg::tmwc_chan_s ev [3];
    generate
        for (gi = 0; gi < 3; gi++) begin : g_chan
            // action read live, so a write hits the next match
            assign ev[gi].action = act_q[2*gi+1 -: 2];
            assign ev[gi].pwm = is_fast;
            // fast pwm toggle only on output A with top at A
            assign ev[gi].toggle_ok = (gi == 0) &&
                                      (emode_q == `TMWC_M_FAST_A);
            assign ev[gi].match = match[gi];
            assign ev[gi].top_evt = clr_top;
            assign ev[gi].force_evt = force_evt[gi];
            tmwc_chan u_chan (
                .pclk(pclk),
                .presetn(presetn),
                .ev(ev[gi]),
                .state(state[gi])
            );
        end
    endgenerate

    //==============================================================
    // read mux
    //==============================================================
    logic [31:0] rdata;
    assign rdata =
        hit_ctrl ? {27'h0, run_q, mode_q} :
        hit_act ? {26'h0, act_q} :
        hit_dir ? {29'h0, dir_q} :
        hit_cnt ? {16'h0, cnt_q} :
        hit_cmpa ? {16'h0, buf_q[0]} :
        hit_cmpb ? {16'h0, buf_q[1]} :
        hit_cmpc ? {16'h0, buf_q[2]} :
        hit_capt ? {16'h0, icr_q} :
        hit_flag ? {27'h0, flag_q} :
        hit_stat ? {24'h0, emode_q, 1'b0, state} :
        32'h0000_0000;

    //==============================================================
    // processes
    //==============================================================
    // apb answer, one access cycle, error on unmapped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= setup_ph;
            pslverr_q <= setup_ph & ~mapped;
            prdata_q <= setup_ph ? rdata : prdata_q;
        end
    end

    // control registers written by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= 4'h0;
            emode_q <= `TMWC_M_NORMAL;
            run_q <= 1'b0;
            act_q <= 6'h00;
            dir_q <= 3'h0;
        end else begin
            emode_q <= emode_d;
            if (wr_en & hit_ctrl) begin
                mode_q <= pwdata[3:0];
                run_q <= pwdata[`TMWC_CTRL_RUN];
            end
            if (wr_en & hit_act) act_q <= pwdata[5:0];
            if (wr_en & hit_dir) dir_q <= pwdata[2:0];
        end
    end

    // counter, capture, flags and match block
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= `TMWC_BOTTOM;
            icr_q <= 16'h0000;
            flag_q <= 5'h00;
            blk_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            icr_q <= icr_d;
            flag_q <= flag_d;
            blk_q <= cnt_wr;
        end
    end

    // compare buffers and active copies
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 3; i++) begin
                buf_q[i] <= 16'h0000;
                cmp_q[i] <= 16'h0000;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (wr_en & hit_cmp[i]) buf_q[i] <= cmp_wval;
                cmp_q[i] <= cmp_d[i];
            end
        end
    end

    // pins: state drives only where direction is output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wave_q <= 3'h0;
            oe_q <= 3'h0;
        end else begin
            wave_q <= state;
            for (int i = 0; i < 3; i++) begin
                oe_q[i] <= dir_q[i] &
                           (act_q[2*i +: 2] != `TMWC_ACT_NONE);
            end
        end
    end

    //==============================================================
    // outputs
    //==============================================================
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign wave_out = wave_q;
    assign wave_oe = oe_q;
    assign flags = flag_q;
endmodule : tmwc_core
`default_nettype wire

// ---- tb/tmwc_core_sva.sv ----
// port checker for the timer mode and waveform core
`default_nettype none
module tmwc_core_sva (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // flags and pins
    input wire logic [4:0] flag_ack,
    input wire logic [2:0] wave_out,
    input wire logic [4:0] flags
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====
    // helper: a clear request of the overflow flag in the last cycle
    logic clr_q;
    logic clr_d;
    assign clr_d = flag_ack[0] | (pready & pwrite & paddr == 8'h24);
    // capture the clear request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clr_q <= 1'b0;
        end else begin
            clr_q <= clr_d;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ====
    // assertions
    a_ready_next: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_err_zero: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("error read not zero");
    a_map_ok: assert property (pready && paddr <= 8'h28 &&
        paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access refused");
    a_unmap_err: assert property (pready && paddr > 8'h28 |-> pslverr)
        else $error("unmapped access accepted");
    a_stat_high: assert property (pready && !pwrite && paddr == 8'h28
        |-> prdata[31:8] == 24'h0)
        else $error("status high bits set");
    a_flag_sticky: assert property (
        $fell(flags[0]) |-> clr_q)
        else $error("overflow flag cleared on its own");
    a_reset_quiet: assert property (
        $rose(presetn) |-> wave_out == 3'h0 && flags == 5'h00)
        else $error("state not cleared by reset");
endmodule : tmwc_core_sva
bind tmwc_core tmwc_core_sva chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flag_ack(flag_ack), .wave_out(wave_out), .flags(flags));
`default_nettype wire

// ---- tb/tmwc_pin_model.sv ----
// pin side model: loads on the waveform pins, capture source
`default_nettype none
module tmwc_pin_model (
    // waveform outputs from the core
    input wire logic [2:0] wave_out,
    input wire logic [2:0] wave_oe,
    // capture level asked for by the bench
    input wire logic capt_lvl,
    // pin levels
    output logic [2:0] pin,
    output logic capt_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // an undriven pin falls to its pull-down level
    assign pin = wave_oe & wave_out;
    // capture source follows the requested level
    assign capt_pin = capt_lvl;
endmodule : tmwc_pin_model
`default_nettype wire

// ---- tb/tb_timer16_mode_waveform_core.sv ----
// self-checking bench for the timer mode and waveform core
`default_nettype none
module tb_timer16_mode_waveform_core;
    timeunit 1ns;
    timeprecision 1ps;
    // ====
    // signals
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [4:0] flag_ack = 5'h00;
    logic capt_lvl = 1'b0;
    logic [31:0] prdata, r;
    logic pready, pslverr, capt_pin, err;
    logic [2:0] wave_out, wave_oe, pin;
    logic [4:0] flags;
    int err_total = 0;
    int check_count = 0;
    int n;
    always #12.5 pclk = ~pclk;
    tmwc_core dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .capt_pin(capt_pin), .flag_ack(flag_ack), .wave_out(wave_out),
        .wave_oe(wave_oe), .flags(flags));
    tmwc_pin_model pins (.wave_out(wave_out), .wave_oe(wave_oe),
        .capt_lvl(capt_lvl), .pin(pin), .capt_pin(capt_pin));
    // ====
    // shared tasks
    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict
    task automatic to();
        err_total++;
        $display("Error at %0t: wait ran out", $time);
        print_verdict();
    endtask : to
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer, then an idle cycle
    task automatic apb(input logic [7:0] a, input logic w,
            input logic [31:0] d);
        int k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
            if (k >= 16) to();
        end while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h0);
        chk(r, e);
    endtask : rd
    task automatic clr();
        flag_ack <= 5'h1f;
        @(posedge pclk);
        flag_ack <= 5'h00;
        wr(8'h24, 32'h1f);
    endtask : clr
    task automatic wait_flag(input int b, input int lim);
        n = 0;
        while (flags[b] !== 1'b1) begin
            @(posedge pclk);
            n++;
            if (n >= lim) to();
        end
    endtask : wait_flag
    // cycles between two changes of an output state
    task automatic gap(input int b, output int p);
        logic v;
        int k = 0;
        v = wave_out[b];
        while (wave_out[b] === v && k < 50) begin
            @(posedge pclk);
            k++;
        end
        v = wave_out[b];
        p = 0;
        while (wave_out[b] === v && p < 50) begin
            @(posedge pclk);
            p++;
        end
    endtask : gap
    // ====
    // scenarios
    task automatic t_reset();
        chk(32'(wave_out), 32'h0);
        rd(8'h28, 32'h0);
        rd(8'h30, 32'h0);
        chk(32'(err), 32'h1);
        $display("reset test done");
    endtask : t_reset
    task automatic t_normal();
        wr(8'h04, 32'h3f);
        wr(8'h10, 32'hfffc);
        clr();
        wr(8'h00, 32'h10);
        wait_flag(0, 40);
        apb(8'h10, 1'b0, 32'h0);
        chk(32'(r < 32'h8), 32'h1);
        capt_lvl <= 1'b1;
        wait_flag(4, 20);
        capt_lvl <= 1'b0;
        wr(8'h00, 32'h0);
        $display("normal test done");
    endtask : t_normal
    task automatic t_ctc();
        int p;
        clr();
        wr(8'h14, 32'h2);
        wr(8'h04, 32'h1);
        wr(8'h08, 32'h1);
        wr(8'h10, 32'h0);
        wr(8'h00, 32'h14);
        gap(0, p);
        chk(p, 3);
        chk(32'(pin[0] === wave_out[0]), 32'h1);
        chk(32'(flags[1]), 32'h1);
        wr(8'h08, 32'h0);
        // enable register follows the direction bit one edge later
        @(posedge pclk);
        chk(32'(wave_oe[0] | pin[0]), 32'h0);
        wr(8'h04, 32'h0);
        gap(0, p);
        chk(p, 50);
        wr(8'h00, 32'h0);
        $display("ctc test done");
    endtask : t_ctc
    task automatic t_fast();
        int ones;
        for (int a = 2; a < 4; a++) begin
            wr(8'h00, 32'h0);
            wr(8'h20, 32'h7);
            wr(8'h18, 32'h2);
            wr(8'h04, 32'(a << 2));
            wr(8'h10, 32'h0);
            clr();
            wr(8'h00, 32'h1e);
            repeat (20) @(posedge pclk);
            ones = 0;
            repeat (16) begin
                @(posedge pclk);
                ones += wave_out[1];
            end
            chk(ones, a == 2 ? 10 : 6);
            chk(32'(flags[0] & flags[4]), 32'h1);
        end
        for (int i = 0; i < 3; i++) begin
            wr(8'h00, 32'h5 + i);
            wr(8'h18, 32'h1234);
            rd(8'h18, 32'h1234 & ((32'h100 << i) - 1));
        end
        wr(8'h00, 32'h0);
        $display("fast test done");
    endtask : t_fast
    // fast pwm with top from compare A, toggle on output A
    task automatic t_top_a();
        int p;
        wr(8'h14, 32'h3);
        wr(8'h04, 32'h1);
        wr(8'h10, 32'h0);
        clr();
        wr(8'h00, 32'h1f);
        gap(0, p);
        chk(p, 4);
        chk(32'(flags[0] & flags[1]), 32'h1);
        // new top waits in the buffer until the next top
        wr(8'h14, 32'h5);
        gap(0, p);
        gap(0, p);
        chk(p, 6);
        wr(8'h00, 32'h0);
        $display("top a test done");
    endtask : t_top_a
    task automatic t_force();
        wr(8'h10, 32'h55);
        clr();
        wr(8'h04, 32'h3);
        wr(8'h0c, 32'h1);
        apb(8'h28, 1'b0, 32'h0);
        chk(32'(r[0]), 32'h1);
        wr(8'h04, 32'h2);
        wr(8'h0c, 32'h1);
        apb(8'h28, 1'b0, 32'h0);
        chk(32'(r[0]), 32'h0);
        rd(8'h10, 32'h55);
        chk(32'(flags[1]), 32'h0);
        wr(8'h00, 32'h1);
        apb(8'h28, 1'b0, 32'h0);
        chk(32'(r[7:4]), 32'h0);
        wr(8'h00, 32'h0);
        $display("force test done");
    endtask : t_force
    task automatic t_missed();
        wr(8'h14, 32'h10);
        wr(8'h10, 32'h20);
        clr();
        wr(8'h00, 32'h14);
        wait_flag(1, 70000);
        chk(32'(n > 65000), 32'h1);
        chk(32'(flags[0]), 32'h1);
        wr(8'h00, 32'h0);
        $display("missed top test done");
    endtask : t_missed
    // ====
    // main sequence
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_normal();
        t_ctc();
        t_fast();
        t_top_a();
        t_force();
        t_missed();
        print_verdict();
    end
endmodule : tb_timer16_mode_waveform_core
`default_nettype wire
